// *** common/asf_consts.vh ***
`ifndef ASF_CONSTS_VH
`define ASF_CONSTS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ASF_ADDR_MODE_CTRL   8'h25
`define ASF_ADDR_OUT_XL      8'h28
`define ASF_ADDR_OUT_XH      8'h29
`define ASF_ADDR_OUT_YL      8'h2a
`define ASF_ADDR_OUT_YH      8'h2b
`define ASF_ADDR_OUT_ZL      8'h2c
`define ASF_ADDR_OUT_ZH      8'h2d
`define ASF_ADDR_WM_LEVEL    8'h2e
`define ASF_ADDR_STATUS      8'h2f
`define ASF_ADDR_FILL_COUNT  8'h30

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ASF_MODE_HI          7
`define ASF_MODE_LO          5
`define ASF_MAG_STORE_BIT    3
`define ASF_STAT_WM_BIT      7
`define ASF_STAT_OVR_BIT     6
`define ASF_STAT_FULL_BIT    5

// ------------------------------------------------------------
// Mode codes
// ------------------------------------------------------------
`define ASF_MODE_BYPASS      3'h0
`define ASF_MODE_FILL_STOP   3'h1
`define ASF_MODE_CONT_STOP   3'h3
`define ASF_MODE_BYP_CONT    3'h4
`define ASF_MODE_CONT        3'h6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ASF_RST_MODE_CTRL    8'h00
`define ASF_RST_WM_LEVEL     8'h00

`endif

// *** src/asf_skid.v ***
`timescale 1ns/1ps
`default_nettype none

// Two-entry buffer, valid/ready on both sides
module asf_skid #(
	parameter W = 56
) (
	input  wire         sys_clk,
	input  wire         rstn,
	input  wire         in_valid,
	input  wire [W-1:0] in_data,
	output reg          in_ready,
	output wire         out_valid,
	output wire [W-1:0] out_data,
	input  wire         out_ready
);
	reg [W-1:0] slot0;
	reg [W-1:0] slot1;
	reg [1:0]   count;
	wire        push;
	wire        pop;
	reg [1:0]   next_count;

	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_valid = (count != 2'h0);
	assign out_data  = slot0;

	// Occupancy after this cycle
	always @*
	begin
		next_count = count;
		if (push & ~pop)
			next_count = count + 2'h1;
		else if (pop & ~push)
			next_count = count - 2'h1;
	end

	// Storage shifts toward slot0 on pop
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			slot0    <= {W{1'b0}};
			slot1    <= {W{1'b0}};
			count    <= 2'h0;
			in_ready <= 1'b1;
		end
		else
		begin
			count    <= next_count;
			in_ready <= (next_count != 2'h2);
			if (pop)
				slot0 <= (count == 2'h2) ? slot1 : in_data;
			else if (push && count == 2'h0)
				slot0 <= in_data;
			if (push && (count - (pop ? 2'h1 : 2'h0)) == 2'h1)
				slot1 <= in_data;
		end
	end
endmodule // asf_skid

`default_nettype wire

// *** src/asf_slot_ram.v ***
`timescale 1ns/1ps
`default_nettype none

// Slot storage, one write port, one read port
module asf_slot_ram #(
	parameter AW = 8,
	parameter W  = 42
) (
	input  wire          sys_clk,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [W-1:0]  wr_data,
	input  wire [AW-1:0] rd_addr,
	output wire [W-1:0]  rd_data
);
	reg [W-1:0] mem [0:(1<<AW)-1];

	// Write on the clock, read as soon as addressed
	always @(posedge sys_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	assign rd_data = mem[rd_addr];
endmodule // asf_slot_ram

`default_nettype wire

// *** src/asf_top.v ***
// How it works
// - Reset leaves bypass; writing 001, 011 or 110 starts storing at once, 100 waits for the event.
// - Mode field bits 7:5: 000 off, 001, 011, 100, 110 decoded.
// - Magnitude store bit with magnitude enable stores magnitude, not axes.
// - Three 14-bit magnitudes pack per slot; counts step per slot.
// - Magnitude enable makes the embedded functions unavailable.
// - Watermark flag set while fill count is at or above level.
// - Status refreshed every cycle, so with every tick, write and read.
// - Status: watermark bit 7, overrun bit 6, full bit 5, rest zero.
// - Overrun set when sample lands on full buffer; cleared by a completed set read.
// - Nine-bit fill count, full flag as MSB, 256 means full.
// - Count up per stored set below 256, down per completed set read.
// - Watermark routes to either pin through its own enable.
// - Full routes to pin one through its own enable.
// - Overrun goes to no pin; it is only polled.
// - Bypass clears content, freezes output registers, stays empty.
// - Fill-and-stop fills to 256, then stops once overrun rises.
// - Output registers show the oldest set; a set read advances.
// - Continuous wraps and overwrites the oldest when full.
// - Continuous-then-stop turns fill-and-stop on a routed event.
// - Bypass-then-continuous stores nothing until the event.
`include "asf_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module asf_top #(
	parameter AW = 8,
	parameter DW = 14
) (
	input  wire          sys_clk,
	input  wire          rstn,
	input  wire [7:0]    reg_addr,
	input  wire [7:0]    reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [7:0]    reg_rdata,
	input  wire          sample_valid,
	input  wire [DW-1:0] sample_x,
	input  wire [DW-1:0] sample_y,
	input  wire [DW-1:0] sample_z,
	input  wire [DW-1:0] sample_mag,
	output wire          sample_ready,
	input  wire          magnitude_enable,
	input  wire          pin1_watermark_route,
	input  wire          pin2_watermark_route,
	input  wire          pin1_full_route,
	input  wire          trigger_event,
	input  wire          trigger_routed,
	output reg           irq_pin_one,
	output reg           irq_pin_two,
	output reg           embedded_functions_available
);
	// ------------------------------------------------------------
	// Mode states
	// ------------------------------------------------------------
	localparam [4:0] MS_OFF       = 5'h01;
	localparam [4:0] MS_FILL      = 5'h02;
	localparam [4:0] MS_CONT      = 5'h04;
	localparam [4:0] MS_WAIT_CONT = 5'h08;
	localparam [4:0] MS_CONT_STOP = 5'h10;

	localparam SW = 3 * DW;
	localparam IW = 4 * DW;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	reg  [7:0]    buffer_mode_control;
	reg  [7:0]    watermark_level;
	reg  [7:0]    buffer_status_flags;
	reg  [7:0]    buffer_fill_count;
	reg  [AW:0]   fill_count;
	reg  [AW-1:0] wr_ptr;
	reg  [AW-1:0] rd_ptr;
	reg           overrun_flag;
	reg           stopped;
	reg  [4:0]    state;
	reg  [1:0]    lane;
	reg  [2*DW-1:0] mag_hold;
	reg  [SW-1:0] out_set;
	reg  [4:0]    next_state;
	reg  [7:0]    rd_mux;

	wire [2:0]    buffer_mode_sel;
	wire          magnitude_store_sel;
	wire          mag_mode;
	wire          sk_valid;
	wire [IW-1:0] sk_data;
	wire          sk_ready;
	wire          take;
	wire          store_on;
	wire          commit;
	wire [SW-1:0] commit_word;
	wire [SW-1:0] oldest;
	wire          fill_count_msb;
	wire          watermark_flag;
	wire          running;
	wire          pop_now;
	wire          mode_wr;
	wire [2:0]    new_mode;
	wire          new_valid;
	wire [DW-1:0] in_x;
	wire [DW-1:0] in_y;
	wire [DW-1:0] in_z;
	wire [DW-1:0] in_mag;

	// ------------------------------------------------------------
	// Input buffering
	// ------------------------------------------------------------
	asf_skid #(
		.W (IW)
	) u_skid (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.in_valid  (sample_valid),
		.in_data   ({sample_mag, sample_x, sample_y, sample_z}),
		.in_ready  (sample_ready),
		.out_valid (sk_valid),
		.out_data  (sk_data),
		.out_ready (sk_ready)
	);

	// Buffered sample split back into fields
	assign in_mag = sk_data[4*DW-1:3*DW];
	assign in_x   = sk_data[3*DW-1:2*DW];
	assign in_y   = sk_data[2*DW-1:DW];
	assign in_z   = sk_data[DW-1:0];

	// ------------------------------------------------------------
	// Decode and flags
	// ------------------------------------------------------------
	assign buffer_mode_sel     = buffer_mode_control[`ASF_MODE_HI:`ASF_MODE_LO];
	assign magnitude_store_sel = buffer_mode_control[`ASF_MAG_STORE_BIT];
	assign mag_mode       = magnitude_enable & magnitude_store_sel;
	assign fill_count_msb = fill_count[AW];
	assign watermark_flag = (fill_count >= {1'b0, watermark_level});
	assign running        = (state != MS_OFF);
	assign mode_wr  = reg_wr & (reg_addr == `ASF_ADDR_MODE_CTRL);
	assign new_mode = reg_wdata[`ASF_MODE_HI:`ASF_MODE_LO];
	// Unlisted codes behave as bypass
	assign new_valid = (new_mode == `ASF_MODE_FILL_STOP) |
		(new_mode == `ASF_MODE_CONT_STOP) |
		(new_mode == `ASF_MODE_BYP_CONT) |
		(new_mode == `ASF_MODE_CONT);

	// Set read completes on the last output byte
	assign pop_now = reg_rd & (reg_addr == `ASF_ADDR_OUT_ZH) & running &
		(fill_count != {(AW+1){1'b0}});

	// Stall the input during a pop so one port suffices
	assign sk_ready = ~pop_now & ~mode_wr;
	assign take     = sk_valid & sk_ready;

	// Storing states; fill-and-stop halts once stopped
	assign store_on = (state == MS_CONT) | (state == MS_CONT_STOP) |
		((state == MS_FILL) & ~stopped);

	// Three magnitudes make one slot
	assign commit = take & store_on & (~mag_mode | (lane == 2'h2));
	assign commit_word = mag_mode ? {mag_hold, in_mag}
		: {in_x, in_y, in_z};

	// ------------------------------------------------------------
	// Slot storage
	// ------------------------------------------------------------
	asf_slot_ram #(
		.AW (AW),
		.W  (SW)
	) u_ram (
		.sys_clk (sys_clk),
		.wr_en   (commit),
		.wr_addr (wr_ptr),
		.wr_data (commit_word),
		.rd_addr (rd_ptr),
		.rd_data (oldest)
	);

	// ------------------------------------------------------------
	// Mode state machine
	// ------------------------------------------------------------
	always @*
	begin
		next_state = state;
		case (state)
			MS_OFF:
				next_state = MS_OFF;
			MS_FILL:
				next_state = MS_FILL;
			MS_CONT:
				next_state = MS_CONT;
			MS_WAIT_CONT:
				if (trigger_event)
					next_state = MS_CONT;
			MS_CONT_STOP:
				if (trigger_event & trigger_routed)
					next_state = MS_FILL;
			default:
				next_state = MS_OFF;
		endcase
		// A new mode write overrides the event paths
		if (mode_wr)
		begin
			if (!new_valid)
				next_state = MS_OFF;
			else if (new_mode != buffer_mode_sel || state == MS_OFF)
			begin
				case (new_mode)
					`ASF_MODE_FILL_STOP: next_state = MS_FILL;
					`ASF_MODE_CONT_STOP: next_state = MS_CONT_STOP;
					`ASF_MODE_BYP_CONT:  next_state = MS_WAIT_CONT;
					`ASF_MODE_CONT:      next_state = MS_CONT;
					default:             next_state = MS_OFF;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Control registers and buffer bookkeeping
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			buffer_mode_control <= `ASF_RST_MODE_CTRL;
			watermark_level     <= `ASF_RST_WM_LEVEL;
			state               <= MS_OFF;
			fill_count          <= {(AW+1){1'b0}};
			wr_ptr              <= {AW{1'b0}};
			rd_ptr              <= {AW{1'b0}};
			overrun_flag        <= 1'b0;
			stopped             <= 1'b0;
			lane                <= 2'h0;
			mag_hold            <= {(2*DW){1'b0}};
		end
		else
		begin
			state <= next_state;
			if (mode_wr)
				buffer_mode_control <= reg_wdata;
			if (reg_wr && reg_addr == `ASF_ADDR_WM_LEVEL)
				watermark_level <= reg_wdata;
			// Partial magnitude slot
			if (take & store_on & mag_mode)
			begin
				if (lane == 2'h2)
					lane <= 2'h0;
				else
				begin
					lane     <= lane + 2'h1;
					mag_hold <= {mag_hold[DW-1:0], in_mag};
				end
			end
			if (mode_wr && (!new_valid || new_mode != buffer_mode_sel))
			begin
				// Bypass empties; any new mode restarts fill
				stopped <= 1'b0;
				lane    <= 2'h0;
				if (!new_valid)
				begin
					fill_count   <= {(AW+1){1'b0}};
					wr_ptr       <= {AW{1'b0}};
					rd_ptr       <= {AW{1'b0}};
					overrun_flag <= 1'b0;
				end
			end
			else if (commit)
			begin
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
				if (fill_count_msb)
				begin
					// Full: drop oldest, flag overrun
					rd_ptr       <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
					overrun_flag <= 1'b1;
					if (state == MS_FILL)
						stopped <= 1'b1;
				end
				else
					fill_count <= fill_count + {{AW{1'b0}}, 1'b1};
			end
			else if (pop_now)
			begin
				rd_ptr       <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
				fill_count   <= fill_count - {{AW{1'b0}}, 1'b1};
				overrun_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Output set registers
	// ------------------------------------------------------------
	// Track the oldest slot; frozen in bypass or when empty
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			out_set <= {SW{1'b0}};
		else if (running && fill_count != {(AW+1){1'b0}})
			out_set <= oldest;
	end

	// ------------------------------------------------------------
	// Status, pins and read data
	// ------------------------------------------------------------
	// Read data mux, axes left-justified in 16 bits
	always @*
	begin
		case (reg_addr)
			`ASF_ADDR_MODE_CTRL:  rd_mux = buffer_mode_control;
			`ASF_ADDR_WM_LEVEL:   rd_mux = watermark_level;
			`ASF_ADDR_STATUS:     rd_mux = buffer_status_flags;
			`ASF_ADDR_FILL_COUNT: rd_mux = buffer_fill_count;
			`ASF_ADDR_OUT_XL:     rd_mux = {out_set[3*DW-9:2*DW], 2'h0};
			`ASF_ADDR_OUT_XH:     rd_mux = out_set[3*DW-1:3*DW-8];
			`ASF_ADDR_OUT_YL:     rd_mux = {out_set[2*DW-9:DW], 2'h0};
			`ASF_ADDR_OUT_YH:     rd_mux = out_set[2*DW-1:2*DW-8];
			`ASF_ADDR_OUT_ZL:     rd_mux = {out_set[DW-9:0], 2'h0};
			`ASF_ADDR_OUT_ZH:     rd_mux = out_set[DW-1:DW-8];
			default:              rd_mux = 8'h00;
		endcase
	end

	// Status refreshed on every clock
	always @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			buffer_status_flags          <= 8'h00;
			buffer_fill_count            <= 8'h00;
			irq_pin_one                  <= 1'b0;
			irq_pin_two                  <= 1'b0;
			embedded_functions_available <= 1'b1;
			reg_rdata                    <= 8'h00;
		end
		else
		begin
			buffer_status_flags <= {watermark_flag, overrun_flag,
				fill_count_msb, 5'h00};
			buffer_fill_count   <= fill_count[7:0];
			// Overrun is deliberately not routed
			irq_pin_one <= (watermark_flag & pin1_watermark_route) |
				(fill_count_msb & pin1_full_route);
			irq_pin_two <= watermark_flag & pin2_watermark_route;
			embedded_functions_available <= ~magnitude_enable;
			if (reg_rd)
				reg_rdata <= rd_mux;
		end
	end

endmodule // asf_top

`default_nettype wire

// *** verif/asf_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asf_consts.vh"

// ----------------------------------------
// Port checker for the sample buffer
// ----------------------------------------
module asf_chk (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       magnitude_enable,
	input wire logic       pin1_watermark_route,
	input wire logic       pin2_watermark_route,
	input wire logic       pin1_full_route,
	input wire logic       irq_pin_one,
	input wire logic       irq_pin_two,
	input wire logic       embedded_functions_available
);
	logic       byp, mode_wr, wr_mode;
	logic [2:0] cnt;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// Mode register write strobe
	assign wr_mode = reg_wr && reg_addr == `ASF_ADDR_MODE_CTRL;

	// Bypass tracking, saturating age count
	always_ff @(posedge sys_clk or negedge rstn)
		if (!rstn)
		begin
			byp     <= 1'b1;
			mode_wr <= 1'b0;
			cnt     <= 3'h7;
		end
		else if (wr_mode)
		begin
			byp     <= reg_wdata[7:5] == `ASF_MODE_BYPASS;
			mode_wr <= 1'b1;
			cnt     <= 3'h0;
		end
		else if (cnt != 3'h7)
			cnt <= cnt + 3'h1;

	sequence s_wm_wr;
		reg_wr && reg_addr == `ASF_ADDR_WM_LEVEL;
	endsequence
	sequence s_wm_rd;
		reg_rd && reg_addr == `ASF_ADDR_WM_LEVEL;
	endsequence

	a_reset_bypass:
		assert property (!mode_wr && reg_rd && reg_addr == `ASF_ADDR_MODE_CTRL
			|=> reg_rdata[7:5] == `ASF_MODE_BYPASS)
		else $error("mode field not bypass before first write");
	a_wm_readback:
		assert property (s_wm_wr ##1 !reg_wr ##1 s_wm_rd
			|=> reg_rdata == $past(reg_wdata, 3))
		else $error("watermark level readback wrong");
	a_status_zero:
		assert property (reg_rd && reg_addr == `ASF_ADDR_STATUS
			|=> reg_rdata[4:0] == 5'h00)
		else $error("status low bits not zero");
	a_bypass_empty:
		assert property (byp && cnt[2] && reg_rd
			&& reg_addr == `ASF_ADDR_FILL_COUNT |=> reg_rdata == 8'h00)
		else $error("fill count not zero in bypass");
	a_pin2_gate:
		assert property (!pin2_watermark_route |=> !irq_pin_two)
		else $error("pin two raised without route");
	a_pin1_gate:
		assert property (!pin1_watermark_route && !pin1_full_route
			|=> !irq_pin_one)
		else $error("pin one raised without route");
	a_func_off:
		assert property (magnitude_enable |=> !embedded_functions_available)
		else $error("functions available with magnitude on");
	a_func_on:
		assert property (!magnitude_enable |=> embedded_functions_available)
		else $error("functions unavailable with magnitude off");
endmodule // asf_chk

bind asf_top asf_chk u_chk (
	.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.magnitude_enable, .pin1_watermark_route, .pin2_watermark_route,
	.pin1_full_route, .irq_pin_one, .irq_pin_two,
	.embedded_functions_available
);

`default_nettype wire

// *** verif/asf_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host side register access model
// ----------------------------------------
module asf_host (
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rdata,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	output var  logic       reg_wr,
	output var  logic       reg_rd
);
	// Idle bus at time zero
	initial
	begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
	end

	// One-cycle write, then scramble the idle lines
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	// One-cycle read, data taken once it has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask
endmodule // asf_host

`default_nettype wire

// *** verif/asf_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "asf_consts.vh"

// ----------------------------------------
// Sample buffer testbench
// ----------------------------------------
module asf_top_tb;
	logic        sys_clk, rstn, reg_wr, reg_rd, sample_valid, sample_ready;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [13:0] sample_x, sample_y, sample_z, sample_mag;
	logic        magnitude_enable, trigger_event, trigger_routed;
	logic        pin1_watermark_route, pin2_watermark_route, pin1_full_route;
	logic        irq_pin_one, irq_pin_two, embedded_functions_available;
	int          error_cnt, n_tests, cyc;

	asf_top dut (
		.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sample_valid, .sample_x, .sample_y, .sample_z, .sample_mag,
		.sample_ready, .magnitude_enable, .pin1_watermark_route,
		.pin2_watermark_route, .pin1_full_route, .trigger_event,
		.trigger_routed, .irq_pin_one, .irq_pin_two,
		.embedded_functions_available
	);
	asf_host host (
		.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd
	);

	// Clock, 10 ns period
	always #5 sys_clk = ~sys_clk;

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk8(d, e);
	endtask

	// Count and flags lag an accepted sample by two cycles
	task automatic settle();
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic set_mode(input logic [2:0] m, input logic mag);
		host.wr(`ASF_ADDR_MODE_CTRL, {m, 1'b0, mag, 3'h0});
		settle();
	endtask

	// One-cycle event pulse, routed to a pin or not
	task automatic pulse_trigger(input logic routed);
		trigger_routed <= routed;
		trigger_event  <= 1'b1;
		@(posedge sys_clk);
		trigger_event  <= 1'b0;
		trigger_routed <= 1'b0;
	endtask

	// Offer n sets, each held until taken
	task automatic push(input int n, input logic [13:0] v);
		int i, w;
		for (i = 0; i < n; i++)
		begin
			sample_valid <= 1'b1;
			sample_x     <= v + i[13:0];
			sample_y     <= v + i[13:0] + 14'h1000;
			sample_z     <= v + i[13:0] + 14'h2000;
			sample_mag   <= v + i[13:0];
			@(posedge sys_clk);
			for (w = 0; sample_ready !== 1'b1 && w < 40; w++)
				@(posedge sys_clk);
		end
		sample_valid <= 1'b0;
		settle();
	endtask

	// Read one whole set, lanes v, v+s, v+2s
	task automatic rd_set(input logic [13:0] v, input logic [13:0] s);
		int          l;
		logic [13:0] e;
		for (l = 0; l < 3; l++)
		begin
			e = v + s * l[13:0];
			rd_chk(`ASF_ADDR_OUT_XL + {l[6:0], 1'b0}, {e[5:0], 2'h0});
			rd_chk(`ASF_ADDR_OUT_XH + {l[6:0], 1'b0}, e[13:6]);
		end
	endtask

	task automatic t_reset();
		rd_chk(`ASF_ADDR_MODE_CTRL, 8'h00);
		chk1(sample_ready, 1'b1);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'h00);
		rd_chk(`ASF_ADDR_STATUS, 8'h80);
		host.wr(`ASF_ADDR_WM_LEVEL, 8'h04);
		rd_chk(`ASF_ADDR_WM_LEVEL, 8'h04);
	endtask

	task automatic t_fill_stop();
		int k;
		pin1_full_route <= 1'b1;
		set_mode(`ASF_MODE_FILL_STOP, 1'b0);
		push(256, 14'h0000);
		chk1(irq_pin_one, 1'b1);
		rd_chk(`ASF_ADDR_STATUS, 8'ha0);
		push(1, 14'h0100);
		rd_chk(`ASF_ADDR_STATUS, 8'he0);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'h00);
		rd_set(14'h0001, 14'h1000);
		rd_chk(`ASF_ADDR_STATUS, 8'h80);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'hff);
		chk1(irq_pin_one, 1'b0);
		push(3, 14'h3000);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'hff);
		for (k = 2; k <= 256; k++)
			rd_set(k[13:0], 14'h1000);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'h00);
		pin1_full_route <= 1'b0;
		set_mode(`ASF_MODE_BYPASS, 1'b0);
		rd_chk(`ASF_ADDR_STATUS, 8'h00);
		rd_chk(`ASF_ADDR_OUT_XH, 8'h04);
	endtask

	task automatic t_continuous();
		pin2_watermark_route <= 1'b1;
		host.wr(`ASF_ADDR_WM_LEVEL, 8'h02);
		set_mode(`ASF_MODE_CONT, 1'b0);
		push(2, 14'h0000);
		chk1(irq_pin_two, 1'b1);
		chk1(irq_pin_one, 1'b0);
		pin1_watermark_route <= 1'b1;
		settle();
		chk1(irq_pin_one, 1'b1);
		pin1_watermark_route <= 1'b0;
		push(256, 14'h0002);
		rd_chk(`ASF_ADDR_STATUS, 8'he0);
		rd_set(14'h0002, 14'h1000);
		pin2_watermark_route <= 1'b0;
		set_mode(`ASF_MODE_BYPASS, 1'b0);
		set_mode(`ASF_MODE_CONT_STOP, 1'b0);
		push(2, 14'h0000);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'h02);
		pulse_trigger(1'b0);
		push(256, 14'h0002);
		pulse_trigger(1'b1);
		push(2, 14'h0200);
		rd_set(14'h0003, 14'h1000);
		set_mode(`ASF_MODE_BYPASS, 1'b0);
	endtask

	task automatic t_byp_cont();
		set_mode(`ASF_MODE_BYP_CONT, 1'b0);
		push(3, 14'h0040);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'h00);
		trigger_event <= 1'b1;
		@(posedge sys_clk);
		trigger_event <= 1'b0;
		push(2, 14'h0050);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'h02);
		rd_set(14'h0050, 14'h1000);
		set_mode(`ASF_MODE_BYPASS, 1'b0);
	endtask

	task automatic t_magnitude();
		magnitude_enable <= 1'b1;
		set_mode(`ASF_MODE_CONT, 1'b1);
		chk1(embedded_functions_available, 1'b0);
		push(3, 14'h0020);
		rd_chk(`ASF_ADDR_FILL_COUNT, 8'h01);
		rd_set(14'h0020, 14'h0001);
		magnitude_enable <= 1'b0;
		set_mode(`ASF_MODE_BYPASS, 1'b0);
		chk1(embedded_functions_available, 1'b1);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Cycle ceiling against hangs
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			end_of_test();
		end
	end

	// Main sequence
	initial
	begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		{sample_valid, magnitude_enable, trigger_event, trigger_routed} = 4'h0;
		{pin1_watermark_route, pin2_watermark_route, pin1_full_route} = 3'h0;
		{sample_x, sample_y, sample_z, sample_mag} = 56'h0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_fill_stop();
		t_continuous();
		t_byp_cont();
		t_magnitude();
		end_of_test();
	end
endmodule // asf_top_tb

`default_nettype wire
